// ===== dv/partial_instruction_execute_asserts.sv
// port checks for the partial instruction executor
`timescale 1ns/10ps
`default_nettype none
module partial_instruction_execute_asserts (
  input wire logic        CLOCK,
  input wire logic        RST,
  input wire logic [13:0] INSTR_DATA,
  input wire logic [10:0] PROGRAM_COUNTER,
  input wire logic [7:0]  ACCUMULATOR,
  input wire logic        ZERO_FLAG,
  input wire logic        CARRY_FLAG,
  input wire logic        STACK_PUSH,
  input wire logic [10:0] RETURN_ADDRESS,
  input wire logic [2:0]  STACK_POINTER
);
  // ==========
  // decode of the word taken at this edge
  wire logic [13:0] w    = INSTR_DATA;
  wire logic        lng  = w[13:12] == 2'h2;
  wire logic        call = w[13:11] == 3'h4;
  wire logic        ldi  = w[13:8] == 6'h18;
  wire logic        orx  = w[13:8] == 6'h06;
  wire logic        rd   = w[13:4] == 10'h002;
  logic             drop;
  // the word after a taken jump or call never executes
  always_ff @(posedge CLOCK)
    drop <= !RST && !drop && lng;
  // a word seen while reset is sampled high is never taken by the core
  wire logic        go   = !drop && !RST;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  a_load_imm: assert property (
    go && ldi |=> ##1 ACCUMULATOR == $past(w[7:0], 2)) else $error("immediate not loaded");
  a_or_acc: assert property (
    go && orx && !w[7] |=> ##1 ZERO_FLAG == (ACCUMULATOR == 8'h00)
      && (ACCUMULATOR | $past(ACCUMULATOR)) == ACCUMULATOR) else $error("bad or result");
  a_acc_kept: assert property (
    go && !(ldi || rd || (orx && !w[7])) |=> ##1 $stable(ACCUMULATOR))
    else $error("accumulator changed");
  a_flags_kept: assert property (
    go && !orx |=> ##1 $stable(ZERO_FLAG) && !CARRY_FLAG) else $error("flags changed");
  a_jump_pc: assert property (
    go && lng |=> ##1 PROGRAM_COUNTER == $past(w[10:0], 2)) else $error("bad branch target");
  a_call_push: assert property (
    go && call |=> ##1 STACK_PUSH && RETURN_ADDRESS == $past(PROGRAM_COUNTER, 2) + 11'h001
      && STACK_POINTER == $past(STACK_POINTER) + 3'h1) else $error("bad call push");
  a_no_push: assert property (
    go && !call |=> ##1 !STACK_PUSH && $stable(STACK_POINTER)) else $error("stray push");
  a_pc_step: assert property (
    go && !lng |=> ##1 PROGRAM_COUNTER == $past(PROGRAM_COUNTER) + 11'h001)
    else $error("counter did not step");
  cover property (go && call);
  cover property (go && orx && !w[7] ##2 ZERO_FLAG);
  cover property (go && lng && !call);
endmodule // partial_instruction_execute_asserts
bind partial_instruction_execute partial_instruction_execute_asserts u_asserts (
  .CLOCK(CLOCK), .RST(RST), .INSTR_DATA(INSTR_DATA), .PROGRAM_COUNTER(PROGRAM_COUNTER),
  .ACCUMULATOR(ACCUMULATOR), .ZERO_FLAG(ZERO_FLAG), .CARRY_FLAG(CARRY_FLAG),
  .STACK_PUSH(STACK_PUSH), .RETURN_ADDRESS(RETURN_ADDRESS), .STACK_POINTER(STACK_POINTER));
`default_nettype wire

// ===== dv/partial_instruction_execute_test.sv
// self-checking bench for the partial instruction executor
`timescale 1ns/10ps
`default_nettype none
module partial_instruction_execute_test;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [13:0] rom [2048];
  logic [10:0] pc;
  logic [10:0] ret;
  logic [7:0]  acc;
  logic        zf;
  logic        cf;
  logic        push;
  logic [2:0]  sp;
  int          miscompares = 0;
  int          tests_run = 0;
  // program memory read combinationally at the fetch address
  wire logic [13:0] instr = rom[pc];
  always #20 clock = ~clock;
  partial_instruction_execute u_partial_instruction_execute (
    .CLOCK(clock), .RST(rst), .INSTR_DATA(instr), .PROGRAM_COUNTER(pc), .ACCUMULATOR(acc),
    .ZERO_FLAG(zf), .CARRY_FLAG(cf), .STACK_PUSH(push), .RETURN_ADDRESS(ret),
    .STACK_POINTER(sp));
  // ==========
  // compares and closing
  task automatic check_data(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_addr(input logic [10:0] got, input logic [10:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t address %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  function automatic logic [7:0] expect_or(input logic [7:0] x, input logic [7:0] y);
    return x | y;
  endfunction
  function automatic logic expect_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  initial
  begin
    #100000;
    miscompares++;
    test_done();
  end
  initial
  begin
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  o;
    logic [6:0]  r;
    logic [3:0]  f;
    logic [10:0] t;
    t = 11'h010;
    foreach (rom[i]) rom[i] = 14'h0000;
    void'($urandom(32'h7DE0));
    repeat (16) @(posedge clock);
    for (int n = 0; n < 24; n++)
    begin
      a = (n == 0) ? 8'h00 : (n == 1) ? 8'hFF : 8'($urandom);
      b = (n < 2) ? 8'h00 : 8'($urandom);
      o = expect_or(a, b);
      r = (n == 0) ? 7'h00 : (n == 1) ? 7'h7F : 7'($urandom);
      f = (n == 0) ? 4'h5 : (n == 1) ? 4'hF : 4'(5 + $urandom % 11);
      @(posedge clock);
      rst <= 1'b1;
      rom[t] <= 14'h0000;
      rom[t + 11'h001] <= 14'h0000;
      t = (n == 1) ? 11'h7FE : 11'(16 + $urandom % 2000);
      rom[0] <= {6'h18, b};
      rom[1] <= {7'h01, r};
      rom[2] <= {6'h18, a};
      rom[3] <= {6'h06, 1'b1, r};
      rom[4] <= {10'h001, f};
      rom[5] <= {6'h18, 8'h00};
      rom[6] <= {6'h06, 1'b0, r};
      rom[7] <= {10'h002, f};
      rom[8] <= {3'h4, t};
      rom[9] <= {6'h18, 8'hFF};
      rom[t] <= {3'h5, 11'h00C};
      rom[t + 11'h001] <= {6'h18, 8'hFF};
      @(posedge clock);
      rst <= 1'b0;
      tick(2);
      check_data(acc, b);
      tick(1);
      check_data(acc, b);
      tick(1);
      check_data(acc, a);
      check_flag(zf, 1'b0);
      tick(1);
      check_data(acc, a);
      check_flag(zf, expect_zero(o));
      tick(1);
      check_flag(zf, expect_zero(o));
      tick(1);
      check_data(acc, 8'h00);
      tick(1);
      check_data(acc, o);
      check_flag(zf, expect_zero(o));
      tick(1);
      check_data(acc, a);
      tick(1);
      check_addr(pc, t);
      check_addr(ret, 11'h009);
      check_flag(push, 1'b1);
      check_data({5'h00, sp}, 8'h01);
      tick(1);
      check_data(acc, a);
      tick(1);
      check_addr(pc, 11'h00C);
      check_flag(push, 1'b0);
      tick(2);
      check_addr(pc, 11'h00E);
      check_data(acc, a);
      check_flag(cf, 1'b0);
    end
    test_done();
  end
endmodule // partial_instruction_execute_test
`default_nettype wire

// ===== hdl/exec_pkg.sv
// constants and types of the partial instruction executor
package exec_pkg;

  // ==========================================================
  // widths
  localparam int PC_W    = 11;
  localparam int INSTR_W = 14;
  localparam int DATA_W  = 8;
  localparam int REG_AW  = 7;
  localparam int SPR_AW  = 4;
  localparam int SP_W    = 3;

  // ==========================================================
  // reset values
  localparam logic [PC_W-1:0]    PC_RESET    = 11'h000;
  localparam logic [DATA_W-1:0]  ACC_RESET   = 8'h00;
  localparam logic [SP_W-1:0]    SP_RESET    = 3'h0;
  localparam logic [INSTR_W-1:0] INSTR_RESET = 14'h0000;

  // ==========================================================
  // instruction encoding
  localparam int OP_LONG_MSB = 13;
  localparam int OP_LONG_LSB = 11;
  localparam int OP_BYTE_LSB = 8;
  localparam int OP_REG_LSB  = 7;
  localparam int OP_SPR_LSB  = 4;
  localparam int DEST_BIT    = 7;

  localparam logic [2:0] OP_LONG_CALL      = 3'h4;
  localparam logic [2:0] OP_LONG_JUMP      = 3'h5;
  localparam logic [5:0] OP_LOAD_IMMEDIATE = 6'h18;
  localparam logic [5:0] OP_OR_ACC_REG     = 6'h06;
  localparam logic [6:0] OP_MOVE_ACC_REG   = 7'h01;
  localparam logic [9:0] OP_WRITE_SPECIAL  = 10'h001;
  localparam logic [9:0] OP_READ_SPECIAL   = 10'h002;
  localparam logic [INSTR_W-1:0] OP_NOP    = 14'h0000;

  localparam logic [SPR_AW-1:0] SPR_FIRST = 4'h5;
  localparam logic [SPR_AW-1:0] SPR_LAST  = 4'hF;

  typedef enum logic [2:0] {
    OPC_NOP   = 3'b000,
    OPC_OR    = 3'b001,
    OPC_WSPR  = 3'b010,
    OPC_RSPR  = 3'b011,
    OPC_JUMP  = 3'b100,
    OPC_CALL  = 3'b101,
    OPC_MOVE_ACC_TO_REG = 3'b110,
    OPC_LDI   = 3'b111
  } opclass_t;

  function automatic opclass_t decode(input logic [INSTR_W-1:0] w);
    if (w[OP_LONG_MSB:OP_LONG_LSB] == OP_LONG_CALL)
      return OPC_CALL;
    if (w[OP_LONG_MSB:OP_LONG_LSB] == OP_LONG_JUMP)
      return OPC_JUMP;
    if (w[OP_LONG_MSB:OP_BYTE_LSB] == OP_LOAD_IMMEDIATE)
      return OPC_LDI;
    if (w[OP_LONG_MSB:OP_BYTE_LSB] == OP_OR_ACC_REG)
      return OPC_OR;
    if (w[OP_LONG_MSB:OP_REG_LSB] == OP_MOVE_ACC_REG)
      return OPC_MOVE_ACC_TO_REG;
    if (w[OP_LONG_MSB:OP_SPR_LSB] == OP_WRITE_SPECIAL)
      return OPC_WSPR;
    if (w[OP_LONG_MSB:OP_SPR_LSB] == OP_READ_SPECIAL)
      return OPC_RSPR;
    return OPC_NOP;
  endfunction

  function automatic logic spr_in_range(input logic [SPR_AW-1:0] a);
    return (a >= SPR_FIRST) && (a <= SPR_LAST);
  endfunction

endpackage

// ===== hdl/exec_regfile.sv
// small register memory with registered read and write-through forwarding
`timescale 1ns/10ps
`default_nettype none
module exec_regfile #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input  wire logic          clock,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data
);

  logic [DW-1:0] mem [2**AW];

  // ==========================================================
  // storage
  always_ff @(posedge clock)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    // forward a same-cycle write so the next instruction sees it
    if (wr_en && (wr_addr == rd_addr))
      rd_data <= wr_data;
    else
      rd_data <= mem[rd_addr];
  end

endmodule // exec_regfile
`default_nettype wire

// ===== hdl/partial_instruction_execute.sv
// fetch and execute stage for a subset of the 8-bit core's instructions
`timescale 1ns/10ps
`default_nettype none
module partial_instruction_execute (
  input  wire logic                          CLOCK,
  input  wire logic                          RST,
  input  wire logic [exec_pkg::INSTR_W-1:0]  INSTR_DATA,
  output logic      [exec_pkg::PC_W-1:0]     PROGRAM_COUNTER,
  output logic      [exec_pkg::DATA_W-1:0]   ACCUMULATOR,
  output logic                               ZERO_FLAG,
  output logic                               CARRY_FLAG,
  output logic                               STACK_PUSH,
  output logic      [exec_pkg::PC_W-1:0]     RETURN_ADDRESS,
  output logic      [exec_pkg::SP_W-1:0]     STACK_POINTER
);

  typedef struct packed {
    logic [exec_pkg::PC_W-1:0]    pc;
    logic [exec_pkg::INSTR_W-1:0] ir;
    logic [exec_pkg::PC_W-1:0]    ir_pc;
    logic                         ir_valid;
    logic [exec_pkg::DATA_W-1:0]  acc;
    logic                         zero;
    logic                         carry;
    logic [exec_pkg::SP_W-1:0]    sp;
    logic                         push;
    logic [exec_pkg::PC_W-1:0]    ret_addr;
  } state_t;

  state_t state;
  state_t next_state;

  exec_pkg::opclass_t            opclass;
  logic [exec_pkg::DATA_W-1:0]   reg_rd_data;
  logic [exec_pkg::DATA_W-1:0]   spr_rd_data;
  logic                          reg_wr_en;
  logic [exec_pkg::DATA_W-1:0]   reg_wr_data;
  logic                          spr_wr_en;
  logic [exec_pkg::DATA_W-1:0]   or_result;
  logic [exec_pkg::REG_AW-1:0]   reg_addr;
  logic [exec_pkg::SPR_AW-1:0]   spr_addr;

  // ==========================================================
  // data registers and second-page special registers
  exec_regfile #(.AW(exec_pkg::REG_AW), .DW(exec_pkg::DATA_W)) u_data_regs (
    .clock   (CLOCK),
    .rd_addr (INSTR_DATA[exec_pkg::REG_AW-1:0]),
    .rd_data (reg_rd_data),
    .wr_en   (reg_wr_en),
    .wr_addr (reg_addr),
    .wr_data (reg_wr_data)
  );

  exec_regfile #(.AW(exec_pkg::SPR_AW), .DW(exec_pkg::DATA_W)) u_special_regs (
    .clock   (CLOCK),
    .rd_addr (INSTR_DATA[exec_pkg::SPR_AW-1:0]),
    .rd_data (spr_rd_data),
    .wr_en   (spr_wr_en),
    .wr_addr (spr_addr),
    .wr_data (state.acc)
  );

  // ==========================================================
  // execute
  always_comb
  begin
    opclass     = state.ir_valid ? exec_pkg::decode(state.ir) : exec_pkg::OPC_NOP;
    reg_addr    = state.ir[exec_pkg::REG_AW-1:0];
    spr_addr    = state.ir[exec_pkg::SPR_AW-1:0];
    or_result   = state.acc | reg_rd_data;
    reg_wr_en   = 1'b0;
    reg_wr_data = state.acc;
    spr_wr_en   = 1'b0;

    next_state          = state;
    // fetch runs one ahead; carry is never touched by this subset
    next_state.pc       = state.pc + 11'h001;
    next_state.ir       = INSTR_DATA;
    next_state.ir_pc    = state.pc;
    next_state.ir_valid = 1'b1;
    next_state.push     = 1'b0;

    unique case (opclass)
      exec_pkg::OPC_NOP:
      begin
        next_state.acc = state.acc;
      end
      exec_pkg::OPC_OR:
      begin
        if (state.ir[exec_pkg::DEST_BIT])
        begin
          reg_wr_en   = 1'b1;
          reg_wr_data = or_result;
        end
        else
          next_state.acc = or_result;
        next_state.zero = (or_result == 8'h00);
      end
      exec_pkg::OPC_WSPR:
      begin
        spr_wr_en = exec_pkg::spr_in_range(spr_addr);
      end
      exec_pkg::OPC_RSPR:
      begin
        if (exec_pkg::spr_in_range(spr_addr))
          next_state.acc = spr_rd_data;
      end
      exec_pkg::OPC_MOVE_ACC_TO_REG:
      begin
        reg_wr_en = 1'b1;
      end
      exec_pkg::OPC_LDI:
      begin
        next_state.acc = state.ir[exec_pkg::DATA_W-1:0];
      end
      exec_pkg::OPC_JUMP:
      begin
        // the already fetched word is dropped, giving the second cycle
        next_state.pc       = state.ir[exec_pkg::PC_W-1:0];
        next_state.ir_valid = 1'b0;
      end
      exec_pkg::OPC_CALL:
      begin
        next_state.pc       = state.ir[exec_pkg::PC_W-1:0];
        next_state.ir_valid = 1'b0;
        next_state.push     = 1'b1;
        next_state.ret_addr = state.ir_pc + 11'h001;
        next_state.sp       = state.sp + 3'h1;
      end
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      state.pc       <= exec_pkg::PC_RESET;
      state.ir       <= exec_pkg::INSTR_RESET;
      state.ir_pc    <= exec_pkg::PC_RESET;
      state.ir_valid <= 1'b0;
      state.acc      <= exec_pkg::ACC_RESET;
      state.zero     <= 1'b0;
      state.carry    <= 1'b0;
      state.sp       <= exec_pkg::SP_RESET;
      state.push     <= 1'b0;
      state.ret_addr <= exec_pkg::PC_RESET;
    end
    else
      state <= next_state;
  end

  // ==========================================================
  // outputs
  assign PROGRAM_COUNTER = state.pc;
  assign ACCUMULATOR     = state.acc;
  assign ZERO_FLAG       = state.zero;
  assign CARRY_FLAG      = state.carry;
  assign STACK_PUSH      = state.push;
  assign RETURN_ADDRESS  = state.ret_addr;
  assign STACK_POINTER   = state.sp;

endmodule // partial_instruction_execute
`default_nettype wire
